//--- design/bsi_defines.svh
// timing constants of the backlight start-up and interface selector
// assumes a 125 MHz core clock; counts are derived from printed times
`ifndef BSI_DEFINES_SVH
`define BSI_DEFINES_SVH

// ****************************************
// clock and counter sizing
// ****************************************
`define BSI_CLK_MHZ        125
`define BSI_CLK_KHZ        125000
`define BSI_CNT_W          23
`define BSI_BITS           10

// ****************************************
// printed times and the switching frequency, in their own units
// ****************************************
`define BSI_SEL_DELAY_US   100
`define BSI_SEL_LOW_US     260
`define BSI_SEL_WIN_MS     1
`define BSI_START_US       2
`define BSI_BIT_MAX_US     360
`define BSI_ACK_HOLD_US    512
`define BSI_EN_SD_US       2500
`define BSI_DIM_SD_MS      20
`define BSI_SOFT_MS        5
`define BSI_SW_KHZ         1200

// ****************************************
// derived cycle counts
// ****************************************
// sized to the counter width so parameter defaults keep every bit on purpose
`define BSI_SEL_DELAY_CYC  (`BSI_CNT_W'(`BSI_SEL_DELAY_US * `BSI_CLK_MHZ))
`define BSI_SEL_LOW_CYC    (`BSI_CNT_W'(`BSI_SEL_LOW_US * `BSI_CLK_MHZ))
`define BSI_SEL_WIN_CYC    (`BSI_CNT_W'(`BSI_SEL_WIN_MS * `BSI_CLK_KHZ))
`define BSI_START_CYC      (`BSI_CNT_W'(`BSI_START_US * `BSI_CLK_MHZ))
`define BSI_BIT_MAX_CYC    (`BSI_CNT_W'(`BSI_BIT_MAX_US * `BSI_CLK_MHZ))
`define BSI_ACK_HOLD_CYC   (`BSI_CNT_W'(`BSI_ACK_HOLD_US * `BSI_CLK_MHZ))
`define BSI_EN_SD_CYC      (`BSI_CNT_W'(`BSI_EN_SD_US * `BSI_CLK_MHZ))
`define BSI_DIM_SD_CYC     (`BSI_CNT_W'(`BSI_DIM_SD_MS * `BSI_CLK_KHZ))
`define BSI_SOFT_CYC       (`BSI_CNT_W'(`BSI_SOFT_MS * `BSI_CLK_KHZ))
`define BSI_SW_HALF_CYC    (`BSI_CLK_KHZ / `BSI_SW_KHZ / 2)
`define BSI_CODE_RESET     9'h1FF

`endif

//--- design/bsi_onewire_rx.sv
// one-wire bit decoder and acknowledge driver on the enable line
// assumes line_i is already synchronised to core_clk_i
`include "bsi_defines.svh"
`default_nettype none
module bsi_onewire_rx
    import bsi_pkg::*;
#(
    parameter logic [`BSI_CNT_W-1:0] BIT_MAX_CYC  = `BSI_BIT_MAX_CYC,
    parameter logic [`BSI_CNT_W-1:0] ACK_HOLD_CYC = `BSI_ACK_HOLD_CYC
) (
    input  wire logic  core_clk_i,
    input  wire logic  reset_i,
    input  wire logic  enable_i,
    input  wire logic  line_i,
    output bsi_cmd_type cmd_o,
    output logic       cmd_valid_o,
    output logic       ack_oe_n_o
);
    localparam logic [`BSI_CNT_W-1:0] START_CYC = `BSI_START_CYC;

    bsi_rx_type             st_q,   st_d;    // receiver state
    logic [`BSI_CNT_W-1:0]  cnt_q,  cnt_d;   // phase length counter
    logic [`BSI_CNT_W-1:0]  low_q,  low_d;   // low phase of current bit
    logic [3:0]             nb_q,   nb_d;    // bits taken
    logic [`BSI_BITS-1:0]   sh_q,   sh_d;    // shift register, msb first
    logic                   vld_q,  vld_d;   // command strobe
    logic                   oen_q,  oen_d;   // ack enable, low drives

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + 1'b1;
        low_d = low_q;
        nb_d  = nb_q;
        sh_d  = sh_q;
        vld_d = 1'b0;
        oen_d = 1'b1;
        case (st_q)
            RX_IDLE: begin
                // a start condition is a high phase of at least START_CYC
                if (!line_i) begin
                    cnt_d = '0;
                    nb_d  = '0;
                    if (cnt_q >= START_CYC) begin
                        st_d = RX_LOW;
                    end
                end else if (cnt_q == '1) begin
                    cnt_d = cnt_q; // saturate while idle
                end
            end
            RX_LOW: begin
                if (cnt_q >= BIT_MAX_CYC) begin
                    st_d = RX_IDLE; // too long, drop the stream
                end else if (line_i) begin
                    cnt_d = '0;
                    if (nb_q == 4'(`BSI_BITS)) begin
                        vld_d = 1'b1;
                        if (sh_q[`BSI_BITS-1]) begin
                            st_d  = RX_ACK;
                            oen_d = 1'b0;
                        end else begin
                            st_d = RX_IDLE;
                        end
                    end else begin
                        low_d = cnt_q;
                        st_d  = RX_HIGH;
                    end
                end
            end
            RX_HIGH: begin
                if (cnt_q >= BIT_MAX_CYC) begin
                    st_d = RX_IDLE; // line idles high, start already met
                end else if (!line_i) begin
                    sh_d  = {sh_q[`BSI_BITS-2:0], cnt_q > low_q};
                    nb_d  = nb_q + 1'b1;
                    cnt_d = '0;
                    st_d  = RX_LOW;
                end
            end
            RX_ACK: begin
                oen_d = 1'b0;
                if (cnt_q >= ACK_HOLD_CYC - 1'b1) begin
                    oen_d = 1'b1;
                    cnt_d = '0;
                    st_d  = RX_IDLE;
                end
            end
            default: begin
                st_d = RX_IDLE;
            end
        endcase
        if (!enable_i) begin
            st_d  = RX_IDLE;
            cnt_d = '0;
            oen_d = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q  <= RX_IDLE;
            cnt_q <= '0;
            low_q <= '0;
            nb_q  <= '0;
            sh_q  <= '0;
            vld_q <= 1'b0;
            oen_q <= 1'b1;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            low_q <= low_d;
            nb_q  <= nb_d;
            sh_q  <= sh_d;
            vld_q <= vld_d;
            oen_q <= oen_d;
        end
    end

    assign cmd_o       = bsi_cmd_type'(sh_q);
    assign cmd_valid_o = vld_q;
    assign ack_oe_n_o  = oen_q;

    // ****************************************
    // checks
    // ****************************************
    property p_ack_fast;
        @(posedge core_clk_i) disable iff (reset_i)
        (st_q == RX_LOW && line_i && nb_q == 4'(`BSI_BITS) && sh_q[9] && enable_i
            && cnt_q < BIT_MAX_CYC) |=> !oen_q && vld_q;
    endproperty
    a_ack_fast: assert property (p_ack_fast) else $error("ack late");
    property p_ack_len;
        @(posedge core_clk_i) disable iff (reset_i)
        !oen_q |-> cnt_q < ACK_HOLD_CYC;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack too long");
    property p_ack_req;
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(oen_q) |-> vld_q && cmd_o.ack_req;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("unrequested ack");
    property p_bit;
        @(posedge core_clk_i) disable iff (reset_i)
        (st_q == RX_HIGH && !line_i && cnt_q < BIT_MAX_CYC && enable_i)
            |=> sh_q[0] == ($past(cnt_q) > $past(low_q));
    endproperty
    a_bit: assert property (p_bit) else $error("bit value wrong");
    c_ack: cover property (@(posedge core_clk_i) $fell(oen_q));
endmodule
`default_nettype wire

//--- design/bsi_pkg.sv
// types shared by the selector top and the one-wire receiver
// assumes nothing beyond the defines header
`default_nettype none
package bsi_pkg;
    // decoded one-wire command: ack request then the code
    typedef struct packed {
        logic       ack_req;
        logic [8:0] code;
    } bsi_cmd_type;

    // sequencer states, gray along start-up
    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b000,
        ST_DETECT   = 3'b001,
        ST_CHECK    = 3'b011,
        ST_SOFT     = 3'b010,
        ST_RUN      = 3'b110,
        ST_HALT     = 3'b111
    } bsi_state_type;

    // receiver states, gray around the bit loop
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_LOW  = 2'b01,
        RX_HIGH = 2'b11,
        RX_ACK  = 2'b10
    } bsi_rx_type;
endpackage
`default_nettype wire

//--- design/bsi_seq_top.sv
// start-up sequencer and dimming interface selector
// assumes asynchronous enable, dimming and sink-ground inputs
`include "bsi_defines.svh"
`default_nettype none
// Functional notes
// - pulse done inside window selects one-wire
// - no pulse in window selects pulse-width
// - short high, long low decodes zero
// - short low, long high decodes one
// - ack low valid right after stream
// - ack released after hold time
// - ack only when requested by command
// - leave shutdown on enable and dimming high
// - grounded sinks disable their channel
// - both sinks grounded blocks start-up
// - long low on either pin shuts down
// - reduced current limit for first interval
// - switch at fixed frequency
// - code all ones after enable, shutdown
module bsi_seq_top
    import bsi_pkg::*;
#(
    parameter logic [`BSI_CNT_W-1:0] SEL_DELAY_CYC = `BSI_SEL_DELAY_CYC,
    parameter logic [`BSI_CNT_W-1:0] SEL_LOW_CYC   = `BSI_SEL_LOW_CYC,
    parameter logic [`BSI_CNT_W-1:0] SEL_WIN_CYC   = `BSI_SEL_WIN_CYC,
    parameter logic [`BSI_CNT_W-1:0] EN_SD_CYC     = `BSI_EN_SD_CYC,
    parameter logic [`BSI_CNT_W-1:0] DIM_SD_CYC    = `BSI_DIM_SD_CYC,
    parameter logic [`BSI_CNT_W-1:0] SOFT_CYC      = `BSI_SOFT_CYC,
    parameter logic [`BSI_CNT_W-1:0] BIT_MAX_CYC   = `BSI_BIT_MAX_CYC,
    parameter logic [`BSI_CNT_W-1:0] ACK_HOLD_CYC  = `BSI_ACK_HOLD_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       en_pin_i,
    input  wire logic       dim_pin_i,
    input  wire logic [1:0] sink_grounded_i,
    output logic            en_pin_o,
    output logic            en_pin_oe_n_o,
    output logic            onewire_sel_o,
    output logic [8:0]      brightness_code_o,
    output logic [1:0]      channel_enable_o,
    output logic            startup_limit_o,
    output logic            switch_o,
    output logic            active_o
);
    localparam logic [7:0] SW_HALF = 8'(`BSI_SW_HALF_CYC);

    // ****************************************
    // input synchronisers
    // ****************************************
    // first stage is read only by the second stage
    logic [3:0] sy1_q;
    logic [3:0] sy2_q;
    logic       en_s;
    logic       dim_s;
    logic [1:0] sink_s;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {sink_grounded_i, dim_pin_i, en_pin_i};
            sy2_q <= sy1_q;
        end
    end
    assign en_s   = sy2_q[0];
    assign dim_s  = sy2_q[1];
    assign sink_s = sy2_q[3:2];

    // ****************************************
    // sequencer state and counters
    // ****************************************
    bsi_state_type          st_q,    st_d;    // sequencer state
    logic [`BSI_CNT_W-1:0]  tmr_q,   tmr_d;   // window or soft start timer
    logic [`BSI_CNT_W-1:0]  enl_q,   enl_d;   // enable low length
    logic [`BSI_CNT_W-1:0]  diml_q,  diml_d;  // dimming low length
    logic                   selok_q, selok_d; // low pulse long enough
    logic                   ow_q,    ow_d;    // one-wire chosen
    logic [1:0]             chen_q,  chen_d;  // channel enables
    logic                   lim_q,   lim_d;   // reduced limit active
    logic                   act_q,   act_d;   // soft start or run
    logic [8:0]             code_q,  code_d;  // brightness code
    logic [7:0]             swc_q,   swc_d;   // switch divider
    logic                   sw_q,    sw_d;    // switch drive
    logic                   shut;             // long-low shutdown request
    bsi_cmd_type            cmd;
    logic                   cmd_vld;
    logic                   ack_oe_n;

    // saturating increment shared by the timer and the low-length counters
    function automatic logic [`BSI_CNT_W-1:0] sat_inc(input logic [`BSI_CNT_W-1:0] v);
        sat_inc = (v == '1) ? v : v + 1'b1;
    endfunction

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        st_d    = st_q;
        tmr_d   = sat_inc(tmr_q);
        enl_d   = en_s  ? '0 : sat_inc(enl_q);
        diml_d  = dim_s ? '0 : sat_inc(diml_q);
        selok_d = selok_q;
        ow_d    = ow_q;
        chen_d  = chen_q;
        lim_d   = 1'b0;
        code_d  = code_q;
        shut    = (enl_q >= EN_SD_CYC) || (diml_q >= DIM_SD_CYC);
        case (st_q)
            ST_SHUTDOWN: begin
                tmr_d   = '0;
                selok_d = 1'b0;
                ow_d    = 1'b0;
                chen_d  = 2'b00;
                code_d  = `BSI_CODE_RESET;
                if (en_s && dim_s) begin
                    st_d = ST_DETECT;
                end
            end
            ST_DETECT: begin
                if (!en_s && tmr_q >= SEL_DELAY_CYC && enl_q >= SEL_LOW_CYC - 1'b1) begin
                    selok_d = 1'b1;
                end
                if (en_s && selok_q && !ow_q) begin
                    ow_d = 1'b1; // pulse completed in window
                end
                if (!en_s && enl_q < SEL_LOW_CYC && tmr_q < SEL_DELAY_CYC) begin
                    selok_d = 1'b0; // low before the delay does not count
                end
                if (tmr_q >= SEL_WIN_CYC - 1'b1) begin
                    st_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                chen_d = ~sink_s;
                tmr_d  = '0;
                st_d   = (&sink_s) ? ST_HALT : ST_SOFT;
            end
            ST_SOFT: begin
                if (tmr_q >= SOFT_CYC - 1'b1) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                lim_d = 1'b0;
            end
            ST_HALT: begin
                chen_d = 2'b00; // stays dark until shutdown
            end
            default: begin
                st_d = ST_SHUTDOWN;
            end
        endcase
        if (cmd_vld && ow_q && (st_q == ST_SOFT || st_q == ST_RUN)) begin
            code_d = cmd.code;
        end
        if (shut && st_q != ST_SHUTDOWN) begin
            st_d   = ST_SHUTDOWN;
            lim_d  = 1'b0;
            chen_d = 2'b00;
            code_d = `BSI_CODE_RESET; // reset when disabled
        end
        // limit and activity follow the next state, so they never lag it
        lim_d = (st_d == ST_SOFT);
        act_d = (st_d == ST_SOFT) || (st_d == ST_RUN);
    end

    // ****************************************
    // switch divider
    // ****************************************
    // runs only while switching is allowed, so a halted part stays quiet
    always_comb begin
        swc_d = '0;
        sw_d  = 1'b0;
        if (st_d == ST_SOFT || st_d == ST_RUN) begin
            swc_d = (swc_q >= SW_HALF - 1'b1) ? 8'h00 : swc_q + 1'b1;
            sw_d  = (swc_q >= SW_HALF - 1'b1) ? ~sw_q : sw_q;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q    <= ST_SHUTDOWN;
            tmr_q   <= '0;
            enl_q   <= '0;
            diml_q  <= '0;
            selok_q <= 1'b0;
            ow_q    <= 1'b0;
            chen_q  <= 2'b00;
            lim_q   <= 1'b0;
            act_q   <= 1'b0;
            code_q  <= `BSI_CODE_RESET;
            swc_q   <= 8'h00;
            sw_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            enl_q   <= enl_d;
            diml_q  <= diml_d;
            selok_q <= selok_d;
            ow_q    <= ow_d;
            chen_q  <= chen_d;
            lim_q   <= lim_d;
            act_q   <= act_d;
            code_q  <= code_d;
            swc_q   <= swc_d;
            sw_q    <= sw_d;
        end
    end

    // ****************************************
    // one-wire receiver
    // ****************************************
    bsi_onewire_rx #(
        .BIT_MAX_CYC  (BIT_MAX_CYC),
        .ACK_HOLD_CYC (ACK_HOLD_CYC)
    ) u_rx (
        .core_clk_i  (core_clk_i),
        .reset_i     (reset_i),
        .enable_i    (ow_q && (st_q == ST_SOFT || st_q == ST_RUN)),
        .line_i      (en_s),
        .cmd_o       (cmd),
        .cmd_valid_o (cmd_vld),
        .ack_oe_n_o  (ack_oe_n)
    );

    assign en_pin_o          = 1'b0; // open drain, only ever pulls low
    assign en_pin_oe_n_o     = ack_oe_n;
    assign onewire_sel_o     = ow_q;
    assign brightness_code_o = code_q;
    assign channel_enable_o  = chen_q;
    assign startup_limit_o   = lim_q;
    assign switch_o          = sw_q;
    assign active_o          = act_q;

    // ****************************************
    // checks
    // ****************************************
    property p_wake;
        @(posedge core_clk_i) disable iff (reset_i)
        (st_q == ST_SHUTDOWN && st_d == ST_DETECT) |-> en_s && dim_s;
    endproperty
    a_wake: assert property (p_wake) else $error("woke without pins high");
    property p_chan;
        @(posedge core_clk_i) disable iff (reset_i)
        (st_q == ST_CHECK && !shut) |=> chen_q == ~$past(sink_s);
    endproperty
    a_chan: assert property (p_chan) else $error("channel enable wrong");
    property p_halt;
        @(posedge core_clk_i) disable iff (reset_i)
        (st_q == ST_CHECK && &sink_s && !shut) |=> st_q == ST_HALT ##1 !sw_q;
    endproperty
    a_halt: assert property (p_halt) else $error("started with no sink");
    property p_en_sd;
        @(posedge core_clk_i) disable iff (reset_i)
        (enl_q >= EN_SD_CYC && st_q != ST_SHUTDOWN) |=> st_q == ST_SHUTDOWN;
    endproperty
    a_en_sd: assert property (p_en_sd) else $error("missed enable shutdown");
    property p_soft;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(active_o) |-> startup_limit_o [*8];
    endproperty
    a_soft: assert property (p_soft) else $error("soft limit missing");
    property p_code;
        @(posedge core_clk_i) disable iff (reset_i)
        (st_q == ST_SHUTDOWN) |=> code_q == `BSI_CODE_RESET;
    endproperty
    a_code: assert property (p_code) else $error("code not default");
    property p_pwm;
        @(posedge core_clk_i) disable iff (reset_i)
        (st_q == ST_DETECT && st_d == ST_CHECK && !selok_q) |=> !ow_q;
    endproperty
    a_pwm: assert property (p_pwm) else $error("one-wire without pulse");
    c_ow:   cover property (@(posedge core_clk_i) $rose(ow_q));
    c_run:  cover property (@(posedge core_clk_i) st_q == ST_RUN && !ow_q);
    c_halt: cover property (@(posedge core_clk_i) st_q == ST_HALT);
    c_cmd:  cover property (@(posedge core_clk_i) cmd_vld && ow_q);
endmodule
`default_nettype wire

//--- tb/backlight_startup_if_select_tb.sv
// bench for the start-up sequencer, shortened counts
// assumes the host model stands on the enable and dimming pins
`default_nettype none
`define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, ac); end end
module backlight_startup_if_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals and instances
    // ****************************************
    logic       core_clk_i = 1'b0;
    logic       reset_i    = 1'b1;
    logic [1:0] sink_q     = 2'b00;  // grounded sinks
    wire logic  line;                // resolved enable line
    wire logic  dim;
    logic       oe_n;
    logic       en_o;                // open-drain level of the enable pin
    logic       ow_sel;
    logic [8:0] code;
    logic [1:0] chan;
    logic       lim;
    logic       sw;
    logic       act;
    int         bad_count = 0;
    int         compares  = 0;
    int         cyc_count = 0;
    int         k;
    int         n;
    // shortened counts keep the run short; the bit timeout keeps its real value
    localparam logic [22:0] SIM_DELAY = 23'd20;
    localparam logic [22:0] SIM_LOW   = 23'd40;
    localparam logic [22:0] SIM_WIN   = 23'd200;
    localparam logic [22:0] SIM_EN_SD = 23'd400;
    localparam logic [22:0] SIM_DIMSD = 23'd800;
    localparam logic [22:0] SIM_SOFT  = 23'd100;
    localparam logic [22:0] SIM_ACK   = 23'd30;
    initial forever #4 core_clk_i = ~core_clk_i;
    bsi_seq_top #(.SEL_DELAY_CYC(SIM_DELAY), .SEL_LOW_CYC(SIM_LOW), .SEL_WIN_CYC(SIM_WIN),
        .EN_SD_CYC(SIM_EN_SD), .DIM_SD_CYC(SIM_DIMSD), .SOFT_CYC(SIM_SOFT),
        .ACK_HOLD_CYC(SIM_ACK)) u_bsi_seq_top (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .en_pin_i(line), .dim_pin_i(dim),
        .sink_grounded_i(sink_q), .en_pin_o(en_o), .en_pin_oe_n_o(oe_n),
        .onewire_sel_o(ow_sel), .brightness_code_o(code), .channel_enable_o(chan),
        .startup_limit_o(lim), .switch_o(sw), .active_o(act));
    bsi_host_model u_bsi_host_model (.core_clk_i(core_clk_i), .ack_oe_n_i(oe_n),
        .line_o(line), .dim_pin_o(dim));
    // ****************************************
    // helpers
    // ****************************************
    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // whole run is near 5000 cycles, so this ceiling only catches hangs
    always @(posedge core_clk_i) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            bad_count++;
            final_report();
        end
    end
    // sinks set for the next start-up, then reset with pins low
    task automatic power_up(input logic [1:0] gnd);
        sink_q <= gnd;
        reset_i <= 1'b1;
        u_bsi_host_model.drive(1'b0, 1'b0, 6);
        reset_i <= 1'b0;
    endtask
    task automatic wait_act();
        for (k = 0; k < 400 && act !== 1'b1; k++) @(posedge core_clk_i);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_pwm();
        power_up(2'b00);
        u_bsi_host_model.drive(1'b1, 1'b0, 300);
        `CHK("active dim low", 1'b0, act)
        u_bsi_host_model.drive(1'b1, 1'b1, 0);
        wait_act();
        `CHK("onewire", 1'b0, ow_sel)
        `CHK("channels", 2'b11, chan)
        `CHK("code", 9'h1FF, code)
        for (n = 0; n < 200 && lim === 1'b1; n++) @(posedge core_clk_i);
        `CHK("limit cycles", 100, n)
        // skip a phase already under way, then time one whole high phase
        for (k = 0; k < 200 && sw === 1'b1; k++) @(posedge core_clk_i);
        for (k = 0; k < 200 && sw === 1'b0; k++) @(posedge core_clk_i);
        for (n = 0; n < 200 && sw === 1'b1; n++) @(posedge core_clk_i);
        `CHK("half period", 52, n)
    endtask
    task automatic t_onewire();
        power_up(2'b10);
        u_bsi_host_model.select_pulse();
        wait_act();
        `CHK("onewire", 1'b1, ow_sel)
        `CHK("channels", 2'b01, chan)
        u_bsi_host_model.frame({1'b1, 9'h0A5});
        for (k = 0; k < 10 && oe_n !== 1'b0; k++) @(posedge core_clk_i);
        `CHK("ack late", 1'b1, k < 10)
        `CHK("ack level", 1'b0, en_o)
        for (n = 0; n < 600 && oe_n === 1'b0; n++) @(posedge core_clk_i);
        `CHK("ack length", 30, n)
        `CHK("code", 9'h0A5, code)
        u_bsi_host_model.frame({1'b0, 9'h15A});
        n = 0;
        repeat (40) @(posedge core_clk_i) n += (oe_n !== 1'b1);
        `CHK("ack unasked", 0, n)
        `CHK("code", 9'h15A, code)
    endtask
    task automatic t_shutdown();
        u_bsi_host_model.drive(1'b0, 1'b1, 410);
        `CHK("active en low", 1'b0, act)
        `CHK("code reset", 9'h1FF, code)
        `CHK("channels", 2'b00, chan)
        u_bsi_host_model.drive(1'b1, 1'b1, 0);
        wait_act();
        u_bsi_host_model.drive(1'b1, 1'b0, 810);
        `CHK("active dim low", 1'b0, act)
    endtask
    task automatic t_halt();
        power_up(2'b11);
        u_bsi_host_model.drive(1'b1, 1'b1, 300);
        `CHK("active", 1'b0, act)
        `CHK("channels", 2'b00, chan)
        n = 0;
        repeat (120) @(posedge core_clk_i) n += (sw !== 1'b0);
        `CHK("switching", 0, n)
    endtask
    initial begin
        @(posedge core_clk_i);
        t_pwm();
        t_onewire();
        t_shutdown();
        t_halt();
        final_report();
    end
endmodule
`default_nettype wire

//--- tb/bsi_host_model.sv
// host gpio model: drives the enable line and the dimming pin
// assumes the device pulls the line low only through ack_oe_n_i
`default_nettype none
module bsi_host_model (
    input  wire logic core_clk_i,
    input  wire logic ack_oe_n_i,
    output logic      line_o,
    output logic      dim_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_drv_q; // host level, released line reads high
    initial en_drv_q = 1'b0;
    initial dim_pin_o = 1'b0;
    assign line_o = en_drv_q & ack_oe_n_i;
    // set both pins on a rising edge, then hold them for n cycles
    task automatic drive(input logic en, input logic dim, input int n);
        en_drv_q <= en;
        dim_pin_o <= dim;
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic select_pulse();
        drive(1'b1, 1'b1, 30);
        drive(1'b0, 1'b1, 60);
        drive(1'b1, 1'b1, 1);
    endtask
    task automatic send_bit(input logic v);
        drive(1'b0, 1'b1, v ? 20 : 50);
        drive(1'b1, 1'b1, v ? 50 : 20);
    endtask
    task automatic frame(input logic [9:0] w);
        drive(1'b1, 1'b1, 260);
        for (int i = 9; i >= 0; i--) begin
            send_bit(w[i]);
        end
        drive(1'b0, 1'b1, 20);
        en_drv_q <= 1'b1;
    endtask
endmodule
`default_nettype wire
